// [hw/rx_gain_params.svh]
`ifndef RX_GAIN_PARAMS_SVH
`define RX_GAIN_PARAMS_SVH

// Indirect register offsets
`define ANT_GAIN_CTRL_OFS   7'h51
`define PREAMBLE_SEARCH_OFS 7'h56
`define SIGNAL_STRENGTH_OFS 7'h5b
`define CRYSTAL_CTRL_OFS    7'h6e

// Reset values
`define ANT_GAIN_CTRL_RST   8'h40
`define PREAMBLE_SEARCH_RST 8'h1e
`define SIGNAL_STRENGTH_RST 8'h00
`define CRYSTAL_CTRL_RST    8'h00

// Field positions
`define SNIFF_EN_BIT        7
`define GAIN_EN_BIT         6
`define GAIN_STEP_LSB       4
`define ANT_SEL_BIT         1
`define FAST_DIV_BIT        0
`define SEARCH_EN_BIT       0
`define CRYSTAL_BYPASS_BIT  5

// Gain step encodings
`define GAIN_STEP_FULL      2'h0
`define GAIN_STEP_CHF_LOW   2'h1
`define GAIN_STEP_RSVD      2'h2
`define GAIN_STEP_ALL_LOW   2'h3

// SPI frame: read flag bit, frame length and command byte length
`define SPI_READ_BIT        7
`define SPI_FRAME_BITS      5'h10
`define SPI_CMD_BITS        5'h08

// Timing
`define CLK_PERIOD_NS       4
`define RSSI_REFRESH_NS     125000
`define RSSI_REFRESH_CYCLES (`RSSI_REFRESH_NS / `CLK_PERIOD_NS)
`define DUTY_HALF_CYCLES    16

`endif

// [hw/rx_gain_pkg.sv]
package rx_gain_pkg;

  typedef struct packed {
    logic ssel_b;
    logic sclk;
    logic mosi;
  } spi_in_type;

  typedef struct packed {
    logic       sniff_start_enable;
    logic       gain_control_enable;
    logic [1:0] gain_step_select;
    logic [1:0] reserved;
    logic       antenna_select_bit;
    logic       fast_diversity_enable;
  } ant_gain_type;

  typedef struct packed {
    logic [2:0] reserved;
    logic       osc_buffer_cycling_enable;
    logic       limiter_cycling_enable;
    logic       power_meter_cycling_enable;
    logic       front_amp_cycling_enable;
    logic       low_power_search_enable;
  } search_ctrl_type;

  typedef enum logic [2:0] {
    SPI_IDLE = 3'b001,
    SPI_CMD  = 3'b010,
    SPI_DATA = 3'b100
  } spi_state_type;

endpackage

// [hw/duty_cycler.sv]
`timescale 1ns/100ps
// One receiver block's on/off gate during low-power search
module duty_cycler
  import rx_gain_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic ce,
  input  wire logic search_active,
  input  wire logic cycling_enable,
  input  wire logic phase,
  output logic      block_on
);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      block_on <= 1'b1;
    end else if (ce) begin
      block_on <= (search_active && cycling_enable) ? phase : 1'b1;
    end
  end

  a_block_normal: assert property (@(posedge mclk) disable iff (!rst_b)
    ce && !(search_active && cycling_enable) |=> block_on)
    else $error("block gated off outside cycling");

  a_block_follows_phase: assert property (@(posedge mclk) disable iff (!rst_b)
    ce && search_active && cycling_enable |=> block_on == $past(phase))
    else $error("cycling block does not follow duty phase");

endmodule

// [hw/receiver_gain_and_search_ctrl.sv]
`timescale 1ns/100ps
`include "rx_gain_params.svh"
module receiver_gain_and_search_ctrl
  import rx_gain_pkg::*;
#(
  parameter int RSSI_REFRESH_CYCLES = `RSSI_REFRESH_CYCLES,
  parameter int DUTY_HALF_CYCLES    = `DUTY_HALF_CYCLES
) (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  input  wire spi_in_type spi_in,
  output logic            spi_miso,
  output logic            spi_miso_oe,
  input  wire logic [1:0] agc_chosen_step,
  input  wire logic [7:0] rssi_measured,
  input  wire logic [7:0] sniff_threshold,
  input  wire logic       demod_request,
  input  wire logic       preamble_searching,
  output logic            demod_run,
  output logic [1:0]      rx_gain_step,
  output logic            gain_control_active,
  output logic            fast_diversity_enable,
  output logic            antenna_select_bit,
  output logic            low_power_search_active,
  output logic            osc_buffer_on,
  output logic            limiter_on,
  output logic            power_meter_on,
  output logic            front_amp_on,
  output logic            crystal_bypass
);

  ant_gain_type    ant_reg;
  search_ctrl_type search_reg;
  logic [7:0]      signal_strength_level;
  logic [7:0]      crystal_reg;

  spi_state_type   spi_state;
  logic            sclk_prev;
  logic [4:0]      bit_cnt;
  logic [7:0]      rx_shift;
  logic [7:0]      tx_shift;
  logic [6:0]      cmd_addr;
  logic            cmd_read;
  logic [7:0]      read_data;
  logic            sclk_rise;
  logic            sclk_fall;
  logic            write_strobe;
  logic [7:0]      write_data;
  logic [7:0]      next_rx;

  logic [31:0]     refresh_cnt;
  logic            refresh_tick;
  logic [31:0]     duty_cnt;
  logic            duty_phase;
  logic            search_active;

  // SPI pins are synchronous inputs; edges found against the last sample
  assign sclk_rise = !spi_in.ssel_b && spi_in.sclk && !sclk_prev;
  assign sclk_fall = !spi_in.ssel_b && !spi_in.sclk && sclk_prev;
  assign next_rx   = {rx_shift[6:0], spi_in.mosi};
  assign write_strobe = sclk_rise && (spi_state == SPI_DATA) && !cmd_read
                        && (bit_cnt == `SPI_FRAME_BITS - 5'h01);
  assign write_data   = next_rx;

  // Register read mux
  always_comb begin
    read_data = 8'h00;
    if (cmd_addr == `ANT_GAIN_CTRL_OFS) begin
      read_data = ant_reg;
      read_data[`GAIN_STEP_LSB +: 2] = ant_reg.gain_control_enable ? agc_chosen_step
                                                                   : ant_reg.gain_step_select;
      read_data[3:2] = 2'h0;
    end else if (cmd_addr == `PREAMBLE_SEARCH_OFS) begin
      read_data = {3'h0, search_reg[4:0]};
    end else if (cmd_addr == `SIGNAL_STRENGTH_OFS) begin
      read_data = signal_strength_level;
    end else if (cmd_addr == `CRYSTAL_CTRL_OFS) begin
      read_data = crystal_reg;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_prev <= 1'b0;
    end else if (ce) begin
      sclk_prev <= spi_in.sclk;
    end
  end

  // SPI frame: command byte (read flag, 7-bit address), then one data byte
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      spi_state <= SPI_IDLE;
      bit_cnt   <= 5'h00;
      rx_shift  <= 8'h00;
      cmd_addr  <= 7'h00;
      cmd_read  <= 1'b0;
    end else if (ce) begin
      case (spi_state)
        SPI_IDLE: begin
          bit_cnt <= 5'h00;
          if (!spi_in.ssel_b) begin
            spi_state <= SPI_CMD;
          end
        end
        SPI_CMD: begin
          if (spi_in.ssel_b) begin
            spi_state <= SPI_IDLE;
          end else if (sclk_rise) begin
            rx_shift <= next_rx;
            bit_cnt  <= bit_cnt + 5'h01;
            if (bit_cnt == `SPI_CMD_BITS - 5'h01) begin
              cmd_addr  <= next_rx[6:0];
              cmd_read  <= next_rx[`SPI_READ_BIT];
              spi_state <= SPI_DATA;
            end
          end
        end
        SPI_DATA: begin
          // Bits past the frame ignored until deselect: one access per select
          if (spi_in.ssel_b) begin
            spi_state <= SPI_IDLE;
          end else if (sclk_rise && bit_cnt != `SPI_FRAME_BITS) begin
            rx_shift <= next_rx;
            bit_cnt  <= bit_cnt + 5'h01;
          end
        end
        default: begin
          spi_state <= SPI_IDLE;
        end
      endcase
    end
  end

  // Read data loaded on the first falling edge after the command byte, then shifted out on falling edges
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tx_shift    <= 8'h00;
      spi_miso    <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else if (ce) begin
      spi_miso_oe <= !spi_in.ssel_b;
      if (spi_in.ssel_b) begin
        tx_shift <= 8'h00;
        spi_miso <= 1'b0;
      end else if (spi_state == SPI_DATA && bit_cnt == `SPI_CMD_BITS && cmd_read && sclk_fall) begin
        spi_miso <= read_data[7];
        tx_shift <= {read_data[6:0], 1'b0};
      end else if (sclk_fall) begin
        spi_miso <= tx_shift[7];
        tx_shift <= {tx_shift[6:0], 1'b0};
      end
    end
  end

  // Writable registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ant_reg     <= ant_gain_type'(`ANT_GAIN_CTRL_RST);
      search_reg  <= search_ctrl_type'(`PREAMBLE_SEARCH_RST);
      crystal_reg <= `CRYSTAL_CTRL_RST;
    end else if (ce && write_strobe) begin
      if (cmd_addr == `ANT_GAIN_CTRL_OFS) begin
        ant_reg          <= ant_gain_type'(write_data);
        ant_reg.reserved <= 2'h0;
      end else if (cmd_addr == `PREAMBLE_SEARCH_OFS) begin
        search_reg <= search_ctrl_type'({3'h0, write_data[4:0]});
      end else if (cmd_addr == `CRYSTAL_CTRL_OFS) begin
        crystal_reg <= {2'h0, write_data[`CRYSTAL_BYPASS_BIT], 5'h00};
      end
    end
  end

  // Periodic signal strength capture
  assign refresh_tick = (refresh_cnt == 32'(RSSI_REFRESH_CYCLES - 1));

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      refresh_cnt           <= 32'h0000_0000;
      signal_strength_level <= `SIGNAL_STRENGTH_RST;
    end else if (ce) begin
      refresh_cnt <= refresh_tick ? 32'h0000_0000 : refresh_cnt + 32'h0000_0001;
      if (refresh_tick) begin
        signal_strength_level <= rssi_measured;
      end
    end
  end

  // Gain stepping: automatic choice or forced level
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rx_gain_step        <= `GAIN_STEP_FULL;
      gain_control_active <= 1'b1;
    end else if (ce) begin
      gain_control_active <= ant_reg.gain_control_enable;
      rx_gain_step <= ant_reg.gain_control_enable ? agc_chosen_step
                                                  : ant_reg.gain_step_select;
    end
  end

  // Sniff start gate for the symbol demodulator
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      demod_run <= 1'b0;
    end else if (ce) begin
      if (!demod_request) begin
        demod_run <= 1'b0;
      end else if (!ant_reg.sniff_start_enable || rssi_measured >= sniff_threshold) begin
        demod_run <= 1'b1;
      end
    end
  end

  // Diversity, antenna and crystal controls
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fast_diversity_enable <= 1'b0;
      antenna_select_bit    <= 1'b0;
      crystal_bypass        <= 1'b0;
    end else if (ce) begin
      fast_diversity_enable <= ant_reg.fast_diversity_enable;
      antenna_select_bit    <= ant_reg.antenna_select_bit;
      crystal_bypass        <= crystal_reg[`CRYSTAL_BYPASS_BIT];
    end
  end

  // Low-power search mode and half-duty phase
  assign search_active = search_reg.low_power_search_enable && preamble_searching;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      low_power_search_active <= 1'b0;
      duty_cnt                <= 32'h0000_0000;
      duty_phase              <= 1'b1;
    end else if (ce) begin
      low_power_search_active <= search_reg.low_power_search_enable;
      if (duty_cnt == 32'(DUTY_HALF_CYCLES - 1)) begin
        duty_cnt   <= 32'h0000_0000;
        duty_phase <= !duty_phase;
      end else begin
        duty_cnt <= duty_cnt + 32'h0000_0001;
      end
    end
  end

  duty_cycler u_osc_buffer (
    .mclk           (mclk),
    .rst_b          (rst_b),
    .ce             (ce),
    .search_active  (search_active),
    .cycling_enable (search_reg.osc_buffer_cycling_enable),
    .phase          (duty_phase),
    .block_on       (osc_buffer_on)
  );

  duty_cycler u_limiter (
    .mclk           (mclk),
    .rst_b          (rst_b),
    .ce             (ce),
    .search_active  (search_active),
    .cycling_enable (search_reg.limiter_cycling_enable),
    .phase          (duty_phase),
    .block_on       (limiter_on)
  );

  duty_cycler u_power_meter (
    .mclk           (mclk),
    .rst_b          (rst_b),
    .ce             (ce),
    .search_active  (search_active),
    .cycling_enable (search_reg.power_meter_cycling_enable),
    .phase          (duty_phase),
    .block_on       (power_meter_on)
  );

  duty_cycler u_front_amp (
    .mclk           (mclk),
    .rst_b          (rst_b),
    .ce             (ce),
    .search_active  (search_active),
    .cycling_enable (search_reg.front_amp_cycling_enable),
    .phase          (duty_phase),
    .block_on       (front_amp_on)
  );

  // Checks
  a_sniff_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    ce && ant_reg.sniff_start_enable && !demod_run && rssi_measured < sniff_threshold |=> !demod_run)
    else $error("demodulator started below sniff threshold");

  a_gain_en_reset: assert property (@(posedge mclk)
    rst_b && !$past(rst_b) |-> ant_reg.gain_control_enable && gain_control_active)
    else $error("gain control not enabled after reset");

  a_forced_gain: assert property (@(posedge mclk) disable iff (!rst_b)
    ce && !ant_reg.gain_control_enable |=> rx_gain_step == $past(ant_reg.gain_step_select))
    else $error("forced gain step not applied");

  a_auto_gain: assert property (@(posedge mclk) disable iff (!rst_b)
    ce && ant_reg.gain_control_enable |=> rx_gain_step == $past(agc_chosen_step))
    else $error("automatic gain step not followed");

  a_fast_div: assert property (@(posedge mclk) disable iff (!rst_b)
    ce |=> fast_diversity_enable == $past(ant_reg.fast_diversity_enable))
    else $error("diversity enable does not follow register");

  a_search_mode: assert property (@(posedge mclk) disable iff (!rst_b)
    ce |=> low_power_search_active == $past(search_reg.low_power_search_enable))
    else $error("search mode does not follow master enable");

  a_rssi_stable: assert property (@(posedge mclk) disable iff (!rst_b)
    !(ce && refresh_tick) |=> $stable(signal_strength_level))
    else $error("signal strength changed off refresh tick");

  a_refresh_bound: assert property (@(posedge mclk) disable iff (!rst_b)
    refresh_cnt < 32'(RSSI_REFRESH_CYCLES))
    else $error("refresh counter beyond period");

  a_reserved_zero: assert property (@(posedge mclk) disable iff (!rst_b)
    ant_reg.reserved == 2'h0 && search_reg.reserved == 3'h0)
    else $error("reserved bits hold nonzero value");

  a_miso_drive: assert property (@(posedge mclk) disable iff (!rst_b)
    ce |=> spi_miso_oe == !$past(spi_in.ssel_b))
    else $error("miso enable does not track select");

  c_write_frame: cover property (@(posedge mclk) disable iff (!rst_b) ce && write_strobe);
  c_sniff_start: cover property (@(posedge mclk) disable iff (!rst_b)
    ant_reg.sniff_start_enable && $rose(demod_run));
  c_search_cycle: cover property (@(posedge mclk) disable iff (!rst_b)
    search_active && $fell(front_amp_on));
  c_rssi_refresh: cover property (@(posedge mclk) disable iff (!rst_b) ce && refresh_tick);

endmodule

// [verif/spi_host_model.sv]
`timescale 1ns/100ps
module spi_host_model
  import rx_gain_pkg::*;
(
  input  wire logic mclk,
  output spi_in_type spi_o,
  input  wire logic spi_miso
);
  int   half               = 2;
  logic crystal_osc_enable = 1'b0;
  initial spi_o = 3'b100;
  // Mode 0 frame, MSB first; fewer than 16 bits aborts it
  task automatic xfer(input logic [15:0] w, input int nbits, output logic [7:0] rd);
    @(negedge mclk);
    spi_o.ssel_b = 1'b0;
    for (int i = 15; i >= 16 - nbits; i--) begin
      spi_o.sclk = 1'b0;
      spi_o.mosi = w[i];
      repeat (half) @(negedge mclk);
      if (i < 8) rd[i] = spi_miso;
      spi_o.sclk = 1'b1;
      repeat (half) @(negedge mclk);
    end
    spi_o.sclk = 1'b0;
    spi_o.mosi = ~spi_o.mosi;
    @(negedge mclk);
    spi_o.ssel_b = 1'b1;
    repeat (3) @(negedge mclk);
  endtask
endmodule

// [verif/tb.sv]
`timescale 1ns/100ps
module tb
  import rx_gain_pkg::*;
;
  localparam int REFRESH = 20;
  logic       mclk = 1'b0;
  logic       rst_b = 1'b0;
  logic       ce, demod_request, preamble_searching;
  spi_in_type spi_in;
  logic       spi_miso, spi_miso_oe, demod_run, gain_control_active, fast_diversity_enable;
  logic       antenna_select_bit, low_power_search_active, crystal_bypass;
  logic       osc_buffer_on, limiter_on, power_meter_on, front_amp_on;
  logic [1:0] rx_gain_step, agc_chosen_step;
  logic [7:0] rssi_measured, sniff_threshold, v;
  logic [6:0] addrs[5] = '{7'h51, 7'h56, 7'h5b, 7'h6e, 7'h40};
  logic [7:0] pat[2] = '{8'h15, 8'h0b};
  logic [31:0] seed = 32'ha809;
  logic [31:0] r;
  int         errors, samples_checked, m_ant, m_srch, m_xtal, m_rssi;
  int         cnt[4];

  always #2 mclk = ~mclk;

  receiver_gain_and_search_ctrl #(.RSSI_REFRESH_CYCLES(REFRESH), .DUTY_HALF_CYCLES(4))
    receiver_gain_and_search_ctrl_inst (.mclk, .rst_b, .ce, .spi_in, .spi_miso, .spi_miso_oe,
    .agc_chosen_step, .rssi_measured, .sniff_threshold, .demod_request, .preamble_searching,
    .demod_run, .rx_gain_step, .gain_control_active, .fast_diversity_enable, .antenna_select_bit,
    .low_power_search_active, .osc_buffer_on, .limiter_on, .power_meter_on, .front_amp_on,
    .crystal_bypass);

  spi_host_model spi_host_model_inst (.mclk(mclk), .spi_o(spi_in), .spi_miso(spi_miso));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [7:0] exp_rd(input logic [6:0] a);
    case (a)
      7'h51: return m_ant[6] ? {m_ant[7:6], agc_chosen_step, m_ant[3:0]} : m_ant[7:0];
      7'h56: return m_srch[7:0];
      7'h5b: return m_rssi[7:0];
      7'h6e: return m_xtal[7:0];
      default: return 8'h00;
    endcase
  endfunction

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t reg got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t pins got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] rd;
    if (a == 7'h56 && m_ant[0]) d[0] = 1'b0;
    if (a == 7'h51 && m_srch[0]) d[0] = 1'b0;
    if (a == 7'h6e && d[5] && spi_host_model_inst.crystal_osc_enable) d[5] = 1'b0;
    spi_host_model_inst.xfer({1'b0, a, d}, 16, rd);
    case (a)
      7'h51: m_ant = d & 8'hf3;
      7'h56: m_srch = d & 8'h1f;
      7'h6e: m_xtal = d & 8'h20;
      default: ;
    endcase
  endtask

  task automatic rd_chk(input logic [6:0] a);
    logic [7:0] q;
    spi_host_model_inst.xfer({1'b1, a, 8'h00}, 16, q);
    chk_reg(q, exp_rd(a));
  endtask

  task automatic chk_pins();
    logic [15:0] e;
    e = {m_ant[6], (m_ant[6] ? agc_chosen_step : m_ant[5:4]), m_ant[0], m_ant[1], m_srch[0], m_xtal[5],
         4'hf, 5'h00};
    chk_pin({gain_control_active, rx_gain_step, fast_diversity_enable, antenna_select_bit,
             low_power_search_active, crystal_bypass, osc_buffer_on, limiter_on, power_meter_on,
             front_amp_on, spi_miso_oe, 4'h0}, e);
  endtask

  task automatic conclude();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #200_000;
    errors++;
    conclude();
  end

  initial begin
    {ce, demod_request, preamble_searching} = 3'b100;
    agc_chosen_step = 2'h2;
    rssi_measured = 8'h00;
    sniff_threshold = 8'h80;
    m_ant = 8'h40;
    m_srch = 8'h1e;
    m_xtal = 0;
    m_rssi = 0;
    repeat (20) @(negedge mclk);
    rst_b = 1'b1;
    foreach (addrs[i]) rd_chk(addrs[i]);
    chk_pins();
    // Forced gain steps with automatic gain off
    for (int c = 0; c < 4; c++) begin
      agc_chosen_step = ~c[1:0];
      wr(7'h51, {2'b00, c[1:0], 4'hf});
      rd_chk(7'h51);
      chk_pins();
    end
    // Random traffic over all places, reserved bits and read-only one included
    for (int k = 0; k < 12; k++) begin
      r = xs();
      agc_chosen_step = r[1:0];
      spi_host_model_inst.half = 2 + int'(r[4]);
      wr(addrs[r[10:8] % 5], r[23:16]);
      rd_chk(addrs[r[10:8] % 5]);
      chk_pins();
    end
    // Frame cut short must not write
    spi_host_model_inst.xfer({1'b0, 7'h6e, ~m_xtal[7:0]}, 12, v);
    rd_chk(7'h6e);
    r = xs();
    rssi_measured = r[7:0];
    repeat (REFRESH + 2) @(negedge mclk);
    m_rssi = r[7:0];
    wr(7'h5b, ~r[7:0]);
    rd_chk(7'h5b);
    // Duty cycling: each pattern cycles two blocks, others left on
    wr(7'h51, 8'h40);
    foreach (pat[j]) begin
      wr(7'h56, pat[j]);
      preamble_searching = 1'b1;
      repeat (3) @(negedge mclk);
      cnt = '{0, 0, 0, 0};
      repeat (32) begin
        @(negedge mclk);
        cnt[0] += osc_buffer_on;
        cnt[1] += limiter_on;
        cnt[2] += power_meter_on;
        cnt[3] += front_amp_on;
      end
      chk_pin({cnt[0][7:0], cnt[1][7:0]}, {(pat[j][4] ? 8'h10 : 8'h20), (pat[j][3] ? 8'h10 : 8'h20)});
      chk_pin({cnt[2][7:0], cnt[3][7:0]}, {(pat[j][2] ? 8'h10 : 8'h20), (pat[j][1] ? 8'h10 : 8'h20)});
      chk_pin({15'h0000, low_power_search_active}, 16'h0001);
      preamble_searching = 1'b0;
      repeat (3) @(negedge mclk);
      chk_pins();
    end
    // Sniff start holds the demodulator below threshold
    wr(7'h51, 8'hc0);
    rssi_measured = 8'h7f;
    demod_request = 1'b1;
    repeat (4) @(negedge mclk);
    chk_pin({15'h0000, demod_run}, 16'h0000);
    rssi_measured = 8'h80;
    @(negedge mclk);
    chk_pin({15'h0000, demod_run}, 16'h0001);
    demod_request = 1'b0;
    repeat (2) @(negedge mclk);
    wr(7'h51, 8'h40);
    rssi_measured = 8'h00;
    demod_request = 1'b1;
    @(negedge mclk);
    chk_pin({15'h0000, demod_run}, 16'h0001);
    // Clock enable low freezes the start gate
    ce = 1'b0;
    demod_request = 1'b0;
    repeat (3) @(negedge mclk);
    chk_pin({15'h0000, demod_run}, 16'h0001);
    ce = 1'b1;
    @(negedge mclk);
    chk_pin({15'h0000, demod_run}, 16'h0000);
    conclude();
  end
endmodule
